// ===== src/mssup_pkg.sv
// Notes on behaviour
// - Thermal model from third motor phase current; trip stops motor, fault code 8.
// - Thermal model cleared on fault acknowledge or auxiliary supply failure.
// - Phase presence checked during soft start and run; missing phase gives fault code 4.
// - Phase loss counted only after one second of continuous absence.
// - Overload and phase faults cleared by front button or remote loop.
// - Ready contact closed while no fault is active, open otherwise.
// - Green lamp steady while auxiliary supply is present.
// - Yellow lamp steady while running clockwise with bypass contacts closed.
// - Red lamp repeats a burst whose pulse count equals the fault code.
// - Separate codes for overtemperature, frequency, sync, temperature circuit, overload.
// - Front button clears fault; still held after two seconds, fault returns.
// - Remote loop acknowledges on closing; closed after two seconds, fault returns.
// - Mains order detected; phases routed so the motor always turns clockwise.
// - Reversing relays change only with zero current and semiconductors off.
// - Isolating variant opens motor isolation relay when off or faulted.
package mssup_pkg;
  typedef enum logic [2:0] {MS_OFF, MS_SWAP, MS_SOFT, MS_RUN, MS_FAULT, MS_ACK} mssup_state_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned PHASE_LOSS_MS = 1000;
  localparam int unsigned ACK_GUARD_MS  = 2000;
  localparam int unsigned FLASH_MS      = 250;
  localparam int unsigned RAMP_MS       = 1000;
  localparam int unsigned SETTLE_MS     = 20;
  localparam int unsigned PHASE_LOSS_CYC = PHASE_LOSS_MS * CYC_PER_MS;
  localparam int unsigned ACK_GUARD_CYC  = ACK_GUARD_MS * CYC_PER_MS;
  localparam int unsigned FLASH_CYC      = FLASH_MS * CYC_PER_MS;
  localparam int unsigned RAMP_CYC       = RAMP_MS * CYC_PER_MS;
  localparam int unsigned SETTLE_CYC     = SETTLE_MS * CYC_PER_MS;
  localparam logic [4:0]  FLASH_GAP_STEPS = 5'h04;

  // ----------------------------------------------------------------
  // Fault codes and thermal model constants
  // ----------------------------------------------------------------
  localparam logic [3:0] FC_NONE      = 4'h0;
  localparam logic [3:0] FC_OVERTEMP  = 4'h2;
  localparam logic [3:0] FC_FREQ      = 4'h3;
  localparam logic [3:0] FC_PHASE     = 4'h4;
  localparam logic [3:0] FC_SYNC      = 4'h5;
  localparam logic [3:0] FC_TEMP_MEAS = 4'h7;
  localparam logic [3:0] FC_OVERLOAD  = 4'h8;
  localparam logic [3:0] FC_MAX       = 4'h8;
  localparam logic [15:0] THERM_COOL  = 16'h0100;
  localparam logic [23:0] TRIP_DEFAULT = 24'h80_0000;
endpackage : mssup_pkg

// ===== src/mssup_top.sv
`timescale 1ns/10ps
module mssup_top
  import mssup_pkg::*;
#(
  parameter int unsigned PHASE_LOSS_CYC = mssup_pkg::PHASE_LOSS_CYC,
  parameter int unsigned ACK_GUARD_CYC  = mssup_pkg::ACK_GUARD_CYC,
  parameter int unsigned FLASH_CYC      = mssup_pkg::FLASH_CYC,
  parameter int unsigned RAMP_CYC       = mssup_pkg::RAMP_CYC,
  parameter int unsigned SETTLE_CYC     = mssup_pkg::SETTLE_CYC,
  parameter int unsigned CUR_W          = 8,
  parameter int unsigned ACC_W          = 24,
  parameter logic [23:0] TRIP_LEVEL     = mssup_pkg::TRIP_DEFAULT,
  parameter bit          ISOLATING      = 1'b1
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire logic             run_cw_i,
  input  wire logic             aux_supply_ok_i,
  input  wire logic [2:0]       phase_present_i,
  input  wire logic             phase_order_cw_i,
  input  wire logic [CUR_W-1:0] sensed_motor_phase_i,
  input  wire logic             sample_valid_i,
  input  wire logic             load_current_zero_i,
  input  wire logic             bypass_closed_i,
  input  wire logic             front_ack_i,
  input  wire logic             remote_ack_return_i,
  input  wire logic             semi_overtemp_i,
  input  wire logic             freq_wrong_i,
  input  wire logic             sync_bad_i,
  input  wire logic             temp_meas_bad_i,
  output logic                  remote_ack_source_o,
  output logic                  gate_semis_o,
  output logic                  bypass_relay_o,
  output logic                  reverse_relay_o,
  output logic                  isolate_close_o,
  output logic                  ready_relay_o,
  output logic                  lamp_power_o,
  output logic                  lamp_run_o,
  output logic                  lamp_fault_o,
  output logic [3:0]            fault_code_o
);
  import mssup_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (ACC_W < 2 * CUR_W || ACC_W > 24 || PHASE_LOSS_CYC < 1 || ACK_GUARD_CYC < 1 ||
      FLASH_CYC < 1 || RAMP_CYC < 1 || SETTLE_CYC < 1) begin : g_bad_param
    $error("mssup_top: unsupported parameter values");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mssup_state_t     state_r, state_nxt;
  logic [31:0]      tmr_r, tmr_nxt;
  logic [31:0]      phl_r, phl_nxt;
  logic [31:0]      fl_cnt_r, fl_cnt_nxt;
  logic [4:0]       step_r, step_nxt;
  logic [3:0]       code_r, code_nxt;
  logic             rev_r, rev_nxt;
  logic             ack_prev_r;
  logic [ACC_W-1:0] acc_r, acc_nxt;

  // Overload wins over temperature circuit, phase, sync, overtemperature, then frequency
  function automatic logic [3:0] fault_pick(input logic ovl, input logic phl, input logic ot,
                                            input logic fq, input logic sy, input logic tm);
    logic [3:0] c;
    c = FC_NONE;
    if (fq) c = FC_FREQ;
    if (ot) c = FC_OVERTEMP;
    if (sy) c = FC_SYNC;
    if (phl) c = FC_PHASE;
    if (tm) c = FC_TEMP_MEAS;
    if (ovl) c = FC_OVERLOAD;
    return c;
  endfunction : fault_pick

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic             ack_lvl   = front_ack_i | remote_ack_return_i;
  wire logic             ack_rise  = ack_lvl & ~ack_prev_r;
  wire logic             motor_act = (state_r == MS_SOFT) || (state_r == MS_RUN);
  wire logic             ph_absent = motor_act & ~(&phase_present_i);
  wire logic             ph_lost   = ph_absent && (phl_r >= PHASE_LOSS_CYC - 1);
  wire logic             overload  = acc_r >= TRIP_LEVEL[ACC_W-1:0];
  wire logic [3:0]       new_code  = fault_pick(overload, ph_lost, semi_overtemp_i,
                                                freq_wrong_i, sync_bad_i, temp_meas_bad_i);
  wire logic             fault_now = new_code != FC_NONE;
  wire logic             need_rev  = ~phase_order_cw_i;
  wire logic             acc_clear = ((state_r == MS_FAULT) && ack_rise) | ~aux_supply_ok_i;

  // Thermal model: heat by current squared, fixed cooling per sample
  wire logic [2*CUR_W-1:0] cur_sq  = sensed_motor_phase_i * sensed_motor_phase_i;
  wire logic [ACC_W:0]     acc_add = {1'b0, acc_r} + (ACC_W+1)'(cur_sq);
  wire logic [ACC_W-1:0]   acc_sat = acc_add[ACC_W] ? {ACC_W{1'b1}} : acc_add[ACC_W-1:0];
  wire logic [ACC_W-1:0]   cool_w  = ACC_W'(THERM_COOL);
  wire logic [ACC_W-1:0]   acc_dec = (acc_sat > cool_w) ? acc_sat - cool_w : '0;

  always_comb begin
    acc_nxt = acc_r;
    if (acc_clear) begin
      acc_nxt = '0;
    end else if (sample_valid_i) begin
      acc_nxt = acc_dec;
    end
  end

  assign phl_nxt = ph_absent ? phl_r + 32'h0000_0001 : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    tmr_nxt   = tmr_r + 32'h0000_0001;
    code_nxt  = code_r;
    rev_nxt   = rev_r;
    case (state_r)
      MS_OFF: begin
        tmr_nxt = '0;
        if (run_cw_i) begin
          state_nxt = (rev_r != need_rev) ? MS_SWAP : MS_SOFT;
        end
      end
      MS_SWAP: begin
        // Contacts only move once current has stayed at zero for the settle time
        if (!load_current_zero_i) begin
          tmr_nxt = '0;
        end else if (tmr_r >= SETTLE_CYC - 1) begin
          rev_nxt   = need_rev;
          state_nxt = MS_SOFT;
          tmr_nxt   = '0;
        end
      end
      MS_SOFT: begin
        if (!run_cw_i) begin
          state_nxt = MS_OFF;
        end else if (tmr_r >= RAMP_CYC - 1) begin
          state_nxt = MS_RUN;
        end
      end
      MS_RUN: begin
        if (!run_cw_i) begin
          state_nxt = MS_OFF;
        end
      end
      MS_FAULT: begin
        tmr_nxt = '0;
        if (ack_rise) begin
          state_nxt = MS_ACK;
        end
      end
      MS_ACK: begin
        if (!ack_lvl) begin
          state_nxt = MS_OFF;
        end else if (tmr_r >= ACK_GUARD_CYC - 1) begin
          state_nxt = MS_FAULT;
          tmr_nxt   = '0;
        end
      end
      default: begin
        state_nxt = MS_OFF;
        tmr_nxt   = '0;
      end
    endcase
    // A new fault overrides everything except an already latched one
    if (fault_now && state_r != MS_FAULT) begin
      state_nxt = MS_FAULT;
      code_nxt  = new_code;
      tmr_nxt   = '0;
      rev_nxt   = rev_r;
    end
  end

  // ----------------------------------------------------------------
  // Fault lamp burst
  // ----------------------------------------------------------------
  wire logic       fl_tick   = fl_cnt_r >= FLASH_CYC - 1;
  wire logic [4:0] step_last = {code_r, 1'b0} + FLASH_GAP_STEPS - 5'h01;
  assign fl_cnt_nxt = (state_r != MS_FAULT || fl_tick) ? 32'h0000_0000 : fl_cnt_r + 32'h0000_0001;
  assign step_nxt   = (state_r != MS_FAULT) ? 5'h00 :
                      (!fl_tick) ? step_r :
                      (step_r >= step_last) ? 5'h00 : step_r + 5'h01;
  // Uses the next code so the first pulse starts on the fault edge itself
  wire logic lamp_fault_nxt = (state_nxt == MS_FAULT) && (step_nxt < {code_nxt, 1'b0}) && !step_nxt[0];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r    <= MS_OFF;
      tmr_r      <= '0;
      phl_r      <= '0;
      fl_cnt_r   <= '0;
      step_r     <= '0;
      code_r     <= FC_NONE;
      rev_r      <= 1'b0;
      ack_prev_r <= 1'b0;
      acc_r      <= '0;
    end else begin
      state_r    <= state_nxt;
      tmr_r      <= tmr_nxt;
      phl_r      <= phl_nxt;
      fl_cnt_r   <= fl_cnt_nxt;
      step_r     <= step_nxt;
      code_r     <= code_nxt;
      rev_r      <= rev_nxt;
      ack_prev_r <= ack_lvl;
      acc_r      <= acc_nxt;
    end
  end

  // Outputs follow the next state so they line up with state_r
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remote_ack_source_o <= 1'b0;
      gate_semis_o        <= 1'b0;
      bypass_relay_o      <= 1'b0;
      reverse_relay_o     <= 1'b0;
      isolate_close_o     <= 1'b0;
      ready_relay_o       <= 1'b0;
      lamp_power_o        <= 1'b0;
      lamp_run_o          <= 1'b0;
      lamp_fault_o        <= 1'b0;
      fault_code_o        <= FC_NONE;
    end else begin
      remote_ack_source_o <= 1'b1;
      gate_semis_o        <= state_nxt == MS_SOFT || state_nxt == MS_RUN;
      bypass_relay_o      <= state_nxt == MS_RUN;
      reverse_relay_o     <= rev_nxt;
      isolate_close_o     <= ISOLATING && (state_nxt == MS_SWAP || state_nxt == MS_SOFT ||
                                           state_nxt == MS_RUN);
      ready_relay_o       <= state_nxt != MS_FAULT;
      lamp_power_o        <= aux_supply_ok_i;
      lamp_run_o          <= state_nxt == MS_RUN && bypass_closed_i;
      lamp_fault_o        <= lamp_fault_nxt;
      fault_code_o        <= (state_nxt == MS_FAULT) ? code_nxt : FC_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_overload_trip: assert property (overload && state_r != MS_FAULT |=>
    state_r == MS_FAULT && code_r == FC_OVERLOAD && !gate_semis_o) else $error("overload did not trip");
  a_model_clear: assert property (!aux_supply_ok_i |=> acc_r == '0)
    else $error("thermal model not cleared");
  a_phase_fault: assert property (ph_lost && !overload && !temp_meas_bad_i && state_r != MS_FAULT |=>
    state_r == MS_FAULT && code_r == FC_PHASE) else $error("phase loss not latched");
  a_phase_time: assert property (state_r != MS_FAULT ##1 state_r == MS_FAULT && code_r == FC_PHASE
    |-> $past(phl_r) >= PHASE_LOSS_CYC - 1) else $error("phase fault too early");
  a_ack_clear: assert property (state_r == MS_FAULT && ack_rise && !fault_now |=>
    state_r == MS_ACK && ready_relay_o) else $error("acknowledge ignored");
  // Outputs still show reset values at the first edge after release, hence the guards
  a_ready_state: assert property ($past(rst_n_i) |-> ready_relay_o == (state_r != MS_FAULT))
    else $error("ready contact wrong");
  a_ack_guard: assert property (state_r == MS_ACK && ack_lvl && tmr_r >= ACK_GUARD_CYC - 1 |=>
    state_r == MS_FAULT) else $error("held acknowledge not refaulted");
  a_swap_quiet: assert property ($changed(rev_r) |-> $past(load_current_zero_i) &&
    $past(state_r) == MS_SWAP) else $error("relay moved under load");
  a_isolate_off: assert property (state_r == MS_OFF || state_r == MS_FAULT |-> !isolate_close_o)
    else $error("isolation relay closed");
  a_fault_hold: assert property (state_r == MS_FAULT && !ack_rise |=>
    state_r == MS_FAULT && $stable(code_r)) else $error("fault not latched");
  a_lamp_dark: assert property (state_r != MS_FAULT |-> !lamp_fault_o)
    else $error("fault lamp lit without fault");

  a_power_lamp: assert property ($past(rst_n_i) |-> lamp_power_o == $past(aux_supply_ok_i))
    else $error("power lamp wrong");

  a_run_lamp: assert property ($past(rst_n_i) |-> lamp_run_o == (state_r == MS_RUN && $past(bypass_closed_i)))
    else $error("run lamp wrong");

  a_code_shown: assert property ($past(rst_n_i) |-> fault_code_o == ((state_r == MS_FAULT) ? code_r : FC_NONE))
    else $error("fault code not shown");

  a_swap_gate: assert property (state_r == MS_SWAP |-> !gate_semis_o)
    else $error("semis on during changeover");

  a_front_guard: assert property (state_r == MS_ACK && front_ack_i && tmr_r >= ACK_GUARD_CYC - 1 |=>
    state_r == MS_FAULT) else $error("held front button not refaulted");

  a_loop_source: assert property ($past(rst_n_i) |-> remote_ack_source_o)
    else $error("remote loop source off");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  c_run_reached: cover property (state_r == MS_SOFT ##1 state_r == MS_RUN);
  c_phase_loss: cover property (state_r != MS_FAULT ##1 state_r == MS_FAULT && code_r == FC_PHASE);
  c_overload: cover property (state_r != MS_FAULT ##1 state_r == MS_FAULT && code_r == FC_OVERLOAD);
  c_ack_release: cover property (state_r == MS_ACK ##1 state_r == MS_OFF);
  c_swap_done: cover property (state_r == MS_SWAP ##1 state_r == MS_SOFT);
endmodule : mssup_top

// ===== test/mssup_motor_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Mains, contacts and motor seen from the starter
// ------------------------------------------------------------
module mssup_motor_model (
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       gate_semis_i,
  input  wire logic       bypass_relay_i,
  input  wire logic [7:0] load_level_i,
  output logic            bypass_closed_o,
  output logic            load_current_zero_o,
  output logic [7:0]      sensed_motor_phase_o,
  output logic            sample_valid_o
);
  logic [1:0] gate_dly_r;
  logic [1:0] tick_r;
  // Current decays two cycles after the semis stop, never at once
  always @(negedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_dly_r      <= 2'h0;
      tick_r          <= 2'h0;
      bypass_closed_o <= 1'b0;
    end else begin
      gate_dly_r      <= {gate_dly_r[0], gate_semis_i};
      tick_r          <= tick_r + 2'h1;
      bypass_closed_o <= bypass_relay_i;
    end
  end
  assign load_current_zero_o  = ~(gate_dly_r[1] | gate_dly_r[0] | gate_semis_i);
  assign sample_valid_o       = (tick_r == 2'h3);
  // Only the third motor phase is measured; between samples the value is junk
  assign sensed_motor_phase_o = sample_valid_o ? (gate_semis_i ? load_level_i : 8'h00)
                                               : ~load_level_i;
endmodule : mssup_motor_model

// ===== test/mssup_top_tb_top.sv
`timescale 1ns/10ps
module mssup_top_tb_top;
  import mssup_pkg::*;
  logic       mclk_i, rst_n_i, run_cw, aux_ok, order_cw, front_ack, remote_ret;
  logic       ot, fq, sy, tm, byp_fb, cur_zero, smp_v;
  logic       src_o, gate_o, byp_o, rev_o, iso_o, ready_o, lp_o, lr_o, lf_o;
  logic [2:0] phase;
  logic [7:0] load, cur;
  logic [3:0] code_o;
  int         bad_count, checked;
  // ------------------------------------------------------------
  // Instances
  // ------------------------------------------------------------
  mssup_top #(.PHASE_LOSS_CYC(20), .ACK_GUARD_CYC(30), .FLASH_CYC(4), .RAMP_CYC(10),
    .SETTLE_CYC(3)) u_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .run_cw_i(run_cw), .aux_supply_ok_i(aux_ok),
    .phase_present_i(phase), .phase_order_cw_i(order_cw), .sensed_motor_phase_i(cur),
    .sample_valid_i(smp_v), .load_current_zero_i(cur_zero), .bypass_closed_i(byp_fb),
    .front_ack_i(front_ack), .remote_ack_return_i(remote_ret), .semi_overtemp_i(ot),
    .freq_wrong_i(fq), .sync_bad_i(sy), .temp_meas_bad_i(tm), .remote_ack_source_o(src_o),
    .gate_semis_o(gate_o), .bypass_relay_o(byp_o), .reverse_relay_o(rev_o),
    .isolate_close_o(iso_o), .ready_relay_o(ready_o), .lamp_power_o(lp_o),
    .lamp_run_o(lr_o), .lamp_fault_o(lf_o), .fault_code_o(code_o));
  mssup_motor_model u_motor (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .gate_semis_i(gate_o),
    .bypass_relay_i(byp_o), .load_level_i(load), .bypass_closed_o(byp_fb),
    .load_current_zero_o(cur_zero), .sensed_motor_phase_o(cur), .sample_valid_o(smp_v));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : tick
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ack(input logic remote);
    if (remote) remote_ret = 1'b1;
    else front_ack = 1'b1;
    tick(3);
    chk(ready_o, 1'b1);
    chk(code_o, FC_NONE);
    front_ack  = 1'b0;
    remote_ret = 1'b0;
    tick(3);
  endtask : ack
  task automatic wait_gate;
    for (int n = 0; n < 20 && gate_o !== 1'b1; n++) tick(1);
  endtask : wait_gate
  task automatic report_and_stop;
    if (bad_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    chk(ready_o, 1'b1);
    chk(src_o, 1'b1);
    chk(lp_o, 1'b1);
    aux_ok = 1'b0;
    tick(2);
    chk(lp_o, 1'b0);
    aux_ok = 1'b1;
    tick(2);
  endtask : t_reset
  task automatic t_run;
    run_cw = 1'b1;
    tick(2);
    chk({gate_o, iso_o, byp_o, lr_o}, 4'hc);
    tick(14);
    chk({gate_o, iso_o, byp_o, lr_o}, 4'hf);
    run_cw = 1'b0;
    tick(2);
    chk({gate_o, iso_o, byp_o, lr_o}, 4'h0);
  endtask : t_run
  task automatic t_codes;
    logic [3:0] codes [4] = '{FC_OVERTEMP, FC_FREQ, FC_SYNC, FC_TEMP_MEAS};
    int   rises;
    logic prev;
    for (int i = 0; i < 4; i++) begin
      run_cw = 1'b1;
      tick(3);
      {tm, sy, fq, ot} = 4'h1 << i;
      tick(2);
      chk(code_o, codes[i]);
      chk({ready_o, gate_o, iso_o}, 4'h0);
      {tm, sy, fq, ot} = 4'h0;
      rises = 0;
      prev  = lf_o;
      // Any window of one full burst period holds exactly one burst
      repeat ((2 * codes[i] + 4) * 4) begin
        tick(1);
        if (lf_o === 1'b1 && prev === 1'b0) rises++;
        prev = lf_o;
      end
      chk(rises[3:0], codes[i]);
      chk({ready_o, gate_o}, 4'h0);
      chk(code_o, codes[i]);
      run_cw = 1'b0;
      ack(i[0]);
    end
  endtask : t_codes
  task automatic t_stuck;
    for (int r = 0; r < 2; r++) begin
      ot = 1'b1;
      tick(2);
      ot = 1'b0;
      if (r == 1) remote_ret = 1'b1;
      else front_ack = 1'b1;
      tick(20);
      chk(ready_o, 1'b1);
      tick(20);
      chk(ready_o, 1'b0);
      chk(code_o, FC_OVERTEMP);
      front_ack  = 1'b0;
      remote_ret = 1'b0;
      tick(2);
      ack(r[0]);
    end
  endtask : t_stuck
  task automatic t_phase;
    run_cw = 1'b1;
    tick(15);
    phase = 3'b101;
    tick(10);
    phase = 3'b111;
    tick(5);
    chk(ready_o, 1'b1);
    phase = 3'b011;
    tick(25);
    chk(code_o, FC_PHASE);
    chk(gate_o, 1'b0);
    phase  = 3'b111;
    run_cw = 1'b0;
    ack(1'b1);
  endtask : t_phase
  task automatic t_overload;
    run_cw = 1'b1;
    load   = 8'hff;
    // At most 100 samples by now, below the default trip level
    tick(400);
    chk(code_o, FC_NONE);
    tick(200);
    chk(code_o, FC_OVERLOAD);
    chk(gate_o, 1'b0);
    load   = 8'h10;
    run_cw = 1'b0;
    ack(1'b0);
    run_cw = 1'b1;
    tick(40);
    chk({ready_o, gate_o}, 4'h3);
    run_cw = 1'b0;
    load   = 8'h00;
    tick(2);
  endtask : t_overload
  task automatic t_swap;
    order_cw = 1'b0;
    run_cw   = 1'b1;
    tick(2);
    chk({gate_o, rev_o}, 4'h0);
    wait_gate();
    chk({gate_o, rev_o}, 4'h3);
    run_cw = 1'b0;
    tick(2);
    chk(rev_o, 1'b1);
    order_cw = 1'b1;
    run_cw   = 1'b1;
    wait_gate();
    chk({gate_o, rev_o}, 4'h2);
    run_cw = 1'b0;
    tick(2);
  endtask : t_swap
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    {rst_n_i, run_cw, order_cw, front_ack, remote_ret, ot, fq, sy, tm} = 9'h040;
    aux_ok    = 1'b1;
    phase     = 3'b111;
    load      = 8'h00;
    bad_count = 0;
    checked   = 0;
    tick(10);
    rst_n_i = 1'b1;
    tick(2);
    t_reset();
    t_run();
    t_codes();
    t_stuck();
    t_phase();
    t_overload();
    t_swap();
    report_and_stop();
  end
endmodule : mssup_top_tb_top
